// ### core/stereo_volume_control_regs.sv
/*
  Control logic of a two-channel volume attenuator: three-wire serial port,
  gain, threshold, status and test registers, mute pin handling and the
  zero-cross / timeout gated gain update.
  Assumes comparator and zero-cross indications arrive asynchronously and
  that the host keeps the serial port timing, with the serial clock
  possibly stopped between frames.
*/
// Functional notes
// [RL1] Reset loads all registers and mutes, whatever the mute pin level.
// [RL2] Unmute needs mute pin high and a nonzero gain written.
// [RL3] Mute pin low mutes both; high restores last gains; zero gain mutes.
// [RL4] Mute entry and exit go through zero-cross and timeout gating.
// [RL5] Test register bit 1 turns the mute pin into an output.
// [RL6] Test mode mutes outputs, rejects gain writes except force latch.
// [RL7] Normal gain write arms zero-cross wait for that channel.
// [RL8] Without zero crossing, pending gain applies after 22 ms timeout.
// [RL9] Write to pending channel replaces value and restarts timeout.
// [RL10] Host checks busy status or waits 30 ms between gain changes.
// [RL11] Channels have independent pending machinery.
// [RL12] Instant commands apply the gain when the write completes.
// [RL13] Host uses instant commands only for single steps.
// [RL14] Instant writes store into the readable gain registers.
// [RL15] One 8-bit threshold register, shared, drives the converter.
// [RL16] Peak bits set on overload, bit 0 right, held until read.
// [RL17] Busy bit set on gain write, cleared when gain applied.
// [RL18] Busy status reads zero when idle; bit 0 right, bit 1 left.
// [RL19] Peak status reads zero when idle; bit 0 right, bit 1 left.
// [RL20] Address bit 2 is read flag; bits 6..3 select; bit 7 picks the side for code 6; others ignored.
// [RL21] Code 9 writes both gated; 7 instant both; 6 instant single.
// [RL22] Reset clears all registers except threshold, set to all ones.
// [RL23] Gain code passes straight to the attenuator; code zero mutes.
// [RL24] Frame is sixteen rising edges, address then data, MSB first.
// [RL25] Read data driven from eighth falling edge, one bit per fall.
// [RL26] Data pin released while port select is high.
// [RL27] Comparator indications synchronised before use.
// [RL28] Status writes and malformed frames change no register.
`timescale 1ns/1ns
module stereo_volume_control_regs #(
  parameter logic [21:0] TIMEOUT_CYCLES = volume_ctrl_pkg::TIMEOUT_CYC
) (
  input  wire logic       clock,                // System clock
  input  wire logic       rstn,                 // Async reset, low
  input  wire logic       control_serial_clock, // Serial port clock
  input  wire logic       port_select_n,        // Serial port select
  input  wire logic       data_in,              // Data pin, input side
  output logic            data_out,             // Data pin, output side
  output logic            data_oe,              // Data pin drive enable
  input  wire logic       mute_input_n,         // Mute pin, input side
  output logic            mute_out,             // Mute pin, test output
  output logic            mute_oe,              // Mute pin drive enable
  input  wire logic       zero_cross_left,      // Left input above zero
  input  wire logic       zero_cross_right,     // Right input above zero
  input  wire logic       peak_over_left,       // Left peak over limit
  input  wire logic       peak_over_right,      // Right peak over limit
  output logic [7:0]      left_gain_out,        // Left attenuator code
  output logic [7:0]      right_gain_out,       // Right attenuator code
  output logic [7:0]      peak_reference_out    // Threshold converter
);

  volume_ctrl_pkg::sys_state_t st_q;
  volume_ctrl_pkg::sys_state_t st_d;
  volume_ctrl_pkg::link_cnt_t  lc_q;
  volume_ctrl_pkg::link_cnt_t  lc_d;
  volume_ctrl_pkg::link_cap_t  cap_q;
  volume_ctrl_pkg::link_cap_t  cap_d;
  volume_ctrl_pkg::link_out_t  oc_q;
  volume_ctrl_pkg::link_out_t  oc_d;
  logic                        link_rst_n;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] read_byte(
    input volume_ctrl_pkg::read_view_t v,
    input logic [3:0]                  sel
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (sel)
      volume_ctrl_pkg::SEL_BUSY:   r = v.busy;
      volume_ctrl_pkg::SEL_PEAK:   r = v.peak;
      volume_ctrl_pkg::SEL_THRESH: r = v.thresh;
      volume_ctrl_pkg::SEL_LEFT:   r = v.left;
      volume_ctrl_pkg::SEL_RIGHT:  r = v.right;
      volume_ctrl_pkg::SEL_TEST:   r = v.test;
      default:                     r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic volume_ctrl_pkg::chan_t chan_step(
    input volume_ctrl_pkg::chan_t c,
    input logic                   zc,
    input logic                   muted,
    input logic                   arm,
    input logic                   wr,
    input logic                   inst,
    input logic [7:0]             wdata,
    input logic [21:0]            tmo
  );
    volume_ctrl_pkg::chan_t n;
    logic [7:0]             target;
    n = c;
    target = muted ? volume_ctrl_pkg::MUTE_CODE : c.gain; // RL3
    if (c.pending)
    begin
      if (zc || c.timer == 22'h0)
      begin
        n.applied = target; // RL7 RL8
        n.pending = 1'b0; // RL17
      end
      else
      begin
        n.timer = c.timer - 22'h1;
      end
    end
    if (arm && target != n.applied) // Arm only if output must move
    begin
      n.pending = 1'b1; // RL4
      n.timer   = tmo - 22'h1;
    end
    if (wr)
    begin
      n.gain = wdata; // RL14
      if (inst)
      begin
        n.applied = muted ? volume_ctrl_pkg::MUTE_CODE : wdata; // RL12
        n.pending = 1'b0;
      end
      else
      begin
        n.pending = 1'b1; // RL9 RL17
        n.timer   = tmo - 22'h1;
      end
    end
    return n;
  endfunction

  // ==========================================================
  // Serial link: bit counter and input shifter
  // Port select high ends a frame even if the serial clock has stopped
  assign link_rst_n = rstn & ~port_select_n; // RL26

  always_comb
  begin
    lc_d = lc_q;
    if (lc_q.cnt != volume_ctrl_pkg::OVER_EDGES)
    begin
      lc_d.cnt = lc_q.cnt + 5'h01;
    end
    lc_d.shift = {lc_q.shift[14:0], data_in}; // RL24
  end

  always_ff @(posedge control_serial_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      lc_q <= '0;
    end
    else
    begin
      lc_q <= lc_d;
    end
  end

  // ==========================================================
  // Serial link: frame capture, survives port select
  always_comb
  begin
    cap_d = cap_q;
    if (lc_q.cnt == volume_ctrl_pkg::FRAME_EDGES - 5'h01)
    begin
      cap_d.word = lc_d.shift; // RL24
      cap_d.tgl  = ~cap_q.tgl;
    end
    if (lc_q.cnt == 5'h00)
    begin
      cap_d.over = 1'b0;
    end
    else if (lc_q.cnt >= volume_ctrl_pkg::FRAME_EDGES)
    begin
      cap_d.over = 1'b1; // RL28
    end
  end

  always_ff @(posedge control_serial_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_q <= '0;
    end
    else
    begin
      cap_q <= cap_d;
    end
  end

  // ==========================================================
  // Serial link: read data on falling edges
  // Read view is frozen in a frame, settled before falling edge 8
  always_comb
  begin
    oc_d = oc_q;
    oc_d.shift = {oc_q.shift[6:0], 1'b0}; // RL25
    if (lc_q.cnt == volume_ctrl_pkg::ADDR_EDGES && !oc_q.oe &&
        lc_q.shift[volume_ctrl_pkg::RW_BIT])
    begin
      oc_d.shift = read_byte(st_q.view, lc_q.shift[6:3]); // RL20 RL25
      oc_d.oe    = 1'b1;
    end
  end

  always_ff @(negedge control_serial_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      oc_q <= '0;
    end
    else
    begin
      oc_q <= oc_d;
    end
  end

  assign data_out = oc_q.shift[7];
  assign data_oe  = oc_q.oe; // RL26

  // ==========================================================
  // System domain
  always_comb
  begin
    logic       cs_rise;
    logic       frame_ok;
    logic       wr;
    logic       rd;
    logic [3:0] sel;
    logic [7:0] wdata;
    logic       test_on;
    logic       muted;
    logic       zc_l;
    logic       zc_r;
    logic       wr_l;
    logic       wr_r;
    logic       inst_l;
    logic       inst_r;
    logic       force_latch;
    logic [1:0] peak_clr;
    cs_rise     = 1'b0;
    frame_ok    = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    sel         = 4'h0;
    wdata       = 8'h00;
    test_on     = 1'b0;
    muted       = 1'b0;
    zc_l        = 1'b0;
    zc_r        = 1'b0;
    wr_l        = 1'b0;
    wr_r        = 1'b0;
    inst_l      = 1'b0;
    inst_r      = 1'b0;
    force_latch = 1'b0;
    peak_clr    = 2'h0;
    st_d        = st_q;
    st_d.s1 = {port_select_n, cap_q.tgl, cap_q.over, mute_input_n,
               zero_cross_left, zero_cross_right,
               peak_over_left, peak_over_right}; // RL27
    st_d.s2        = st_q.s1; // RL27
    st_d.cs_prev   = st_q.s2.cs_n;
    st_d.zc_l_prev = st_q.s2.zc_l;
    st_d.zc_r_prev = st_q.s2.zc_r;

    // Commit only on a frame that toggled and did not overrun
    cs_rise  = st_q.s2.cs_n & ~st_q.cs_prev;
    frame_ok = cs_rise & (st_q.s2.tgl != st_q.tgl_seen) &
               ~st_q.s2.over; // RL24 RL28
    if (cs_rise)
    begin
      st_d.tgl_seen = st_q.s2.tgl;
    end
    sel   = cap_q.word[14:11]; // RL20
    rd    = frame_ok & cap_q.word[8 + volume_ctrl_pkg::RW_BIT];
    wr    = frame_ok & ~cap_q.word[8 + volume_ctrl_pkg::RW_BIT];
    wdata = cap_q.word[7:0];
    test_on = st_q.test[volume_ctrl_pkg::TEST_PIN_BIT];
    muted   = ~st_q.s2.mute_n | test_on; // RL3 RL6
    st_d.muted_prev = muted;
    zc_l = st_q.s2.zc_l & ~st_q.zc_l_prev; // RL7
    zc_r = st_q.s2.zc_r & ~st_q.zc_r_prev;
    if (wr)
    begin
      unique case (sel)
        volume_ctrl_pkg::SEL_THRESH: st_d.thresh = wdata; // RL15
        volume_ctrl_pkg::SEL_TEST:   st_d.test   = wdata; // RL5
        volume_ctrl_pkg::SEL_LEFT:   wr_l = ~test_on; // RL6
        volume_ctrl_pkg::SEL_RIGHT:  wr_r = ~test_on;
        volume_ctrl_pkg::CMD_BOTH:
        begin
          wr_l = ~test_on; // RL21
          wr_r = ~test_on;
        end
        volume_ctrl_pkg::CMD_INST_ONE:
        begin
          // Side chosen by address bit 7
          wr_l   = ~test_on & cap_q.word[8 + volume_ctrl_pkg::INST_SIDE_BIT];
          wr_r   = ~test_on & ~cap_q.word[8 + volume_ctrl_pkg::INST_SIDE_BIT];
          inst_l = 1'b1; // RL21
          inst_r = 1'b1;
        end
        volume_ctrl_pkg::CMD_INST_BOTH:
        begin
          wr_l        = ~test_on; // RL21
          wr_r        = ~test_on;
          inst_l      = 1'b1;
          inst_r      = 1'b1;
          force_latch = test_on; // RL6
        end
        default:; // RL28
      endcase
    end

    st_d.left  = chan_step(st_q.left, zc_l, muted,
                           muted != st_q.muted_prev, wr_l, inst_l, wdata,
                           TIMEOUT_CYCLES); // RL11
    st_d.right = chan_step(st_q.right, zc_r, muted,
                           muted != st_q.muted_prev, wr_r, inst_r, wdata,
                           TIMEOUT_CYCLES); // RL11
    if (force_latch)
    begin
      st_d.left.gain  = wdata; // RL6
      st_d.right.gain = wdata;
    end
    if (test_on)
    begin
      // Outputs stay silent; leaving test re-arms via the mute change
      st_d.left.applied   = volume_ctrl_pkg::MUTE_CODE; // RL6
      st_d.left.pending   = 1'b0;
      st_d.right.applied  = volume_ctrl_pkg::MUTE_CODE;
      st_d.right.pending  = 1'b0;
    end

    // Clear only what the reader saw; a new overload wins
    peak_clr = (rd && sel == volume_ctrl_pkg::SEL_PEAK) ?
               st_q.view.peak[1:0] : 2'h0; // RL16
    st_d.peak = st_q.peak & ~peak_clr;
    if (st_q.s2.pk_r)
    begin
      st_d.peak[volume_ctrl_pkg::STAT_RIGHT] = 1'b1; // RL16 RL19
    end
    if (st_q.s2.pk_l)
    begin
      st_d.peak[volume_ctrl_pkg::STAT_LEFT] = 1'b1; // RL16 RL19
    end

    // Read view tracks state only while the port is idle
    if (st_q.s2.cs_n)
    begin
      st_d.view.busy   = {6'h00, st_q.left.pending,
                          st_q.right.pending}; // RL18
      st_d.view.peak   = {6'h00, st_q.peak}; // RL19
      st_d.view.thresh = st_q.thresh;
      st_d.view.left   = st_q.left.gain; // RL14
      st_d.view.right  = st_q.right.gain;
      st_d.view.test   = st_q.test;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q             <= '0; // RL1 RL22
      st_q.s1.cs_n     <= 1'b1;
      st_q.s2.cs_n     <= 1'b1;
      st_q.cs_prev     <= 1'b1;
      st_q.muted_prev  <= 1'b1; // RL1
      st_q.left.gain   <= volume_ctrl_pkg::RST_GAIN;
      st_q.right.gain  <= volume_ctrl_pkg::RST_GAIN;
      st_q.thresh      <= volume_ctrl_pkg::RST_THRESH; // RL22
      st_q.test        <= volume_ctrl_pkg::RST_TEST;
      st_q.peak        <= volume_ctrl_pkg::RST_STAT;
      st_q.view.thresh <= volume_ctrl_pkg::RST_THRESH;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign left_gain_out      = st_q.left.applied; // RL2 RL23
  assign right_gain_out     = st_q.right.applied; // RL23
  assign peak_reference_out = st_q.thresh; // RL15
  assign mute_oe  = st_q.test[volume_ctrl_pkg::TEST_PIN_BIT]; // RL5
  assign mute_out = st_q.s2.zc_l;

endmodule

// ### core/volume_ctrl_pkg.sv
/*
  Shared constants and state types for the stereo volume control register
  bank: command codes, address-byte fields, reset values, the gain update
  timeout and the packed state records of both clock domains.
  Assumes a 125 MHz system clock; the serial port clock is independent.
*/
package volume_ctrl_pkg;

  // ==========================================================
  // Register and command codes (address byte bits 6..3)
  localparam logic [3:0] SEL_BUSY      = 4'ha;
  localparam logic [3:0] SEL_PEAK      = 4'hb;
  localparam logic [3:0] SEL_THRESH    = 4'hc;
  localparam logic [3:0] SEL_LEFT      = 4'hd;
  localparam logic [3:0] SEL_RIGHT     = 4'he;
  localparam logic [3:0] SEL_TEST      = 4'hf;
  localparam logic [3:0] CMD_BOTH      = 4'h9;
  localparam logic [3:0] CMD_INST_ONE  = 4'h6;
  localparam logic [3:0] CMD_INST_BOTH = 4'h7;

  // ==========================================================
  // Field positions
  localparam int unsigned RW_BIT        = 2;
  localparam int unsigned SEL_LSB       = 3;
  localparam int unsigned INST_SIDE_BIT = 7;
  localparam int unsigned TEST_PIN_BIT  = 1;
  localparam int unsigned STAT_RIGHT    = 0;
  localparam int unsigned STAT_LEFT     = 1;

  // ==========================================================
  // Frame edge counts
  localparam logic [4:0] ADDR_EDGES  = 5'h08;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [4:0] OVER_EDGES  = 5'h11;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_GAIN   = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'hff;
  localparam logic [7:0] RST_TEST   = 8'h00;
  localparam logic [1:0] RST_STAT   = 2'h0;
  localparam logic [7:0] MUTE_CODE  = 8'h00;

  // ==========================================================
  // Zero-cross timeout
  localparam int unsigned TIMEOUT_MS  = 22;
  localparam int unsigned CLOCK_HZ    = 125000000;
  localparam logic [21:0] TIMEOUT_CYC =
    22'(TIMEOUT_MS * (CLOCK_HZ / 1000));

  // ==========================================================
  // State records
  typedef struct packed {
    logic [7:0]  gain;
    logic [7:0]  applied;
    logic        pending;
    logic [21:0] timer;
  } chan_t;

  typedef struct packed {
    logic [7:0] busy;
    logic [7:0] peak;
    logic [7:0] thresh;
    logic [7:0] left;
    logic [7:0] right;
    logic [7:0] test;
  } read_view_t;

  typedef struct packed {
    logic cs_n;
    logic tgl;
    logic over;
    logic mute_n;
    logic zc_l;
    logic zc_r;
    logic pk_l;
    logic pk_r;
  } sync_t;

  typedef struct packed {
    sync_t      s1;
    sync_t      s2;
    logic       cs_prev;
    logic       zc_l_prev;
    logic       zc_r_prev;
    logic       tgl_seen;
    logic       muted_prev;
    chan_t      left;
    chan_t      right;
    logic [7:0] thresh;
    logic [7:0] test;
    logic [1:0] peak;
    read_view_t view;
  } sys_state_t;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] shift;
  } link_cnt_t;

  typedef struct packed {
    logic [15:0] word;
    logic        tgl;
    logic        over;
  } link_cap_t;

  typedef struct packed {
    logic [7:0] shift;
    logic       oe;
  } link_out_t;

endpackage

// ### verification/host_serial_model.sv
/*
  Host side of the three-wire serial port, 12 ns serial clock.
  Assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ns
module host_serial_model (
  output logic      sclk, // Serial clock, still between frames
  output logic      cs_n, // Frame select
  output logic      din,  // Resolved data pin level
  input  wire logic dout, // Device data drive
  input  wire logic doe   // Device drive enable
);
  logic drv;
  logic hbit;
  // Released pin shows the inverse of the last host bit
  assign din = drv ? hbit : (doe ? dout : ~hbit);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
    hbit = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input int n, output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 8'h00;
    cs_n = 1'b0;
    drv = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      hbit = (i < 16) ? w[15 - i] : 1'b0;
      #6 sclk = 1'b1;
      if (i >= 8)
        q = {q[6:0], din};
      #3;
      if (i == 7 && a[2])
        drv = 1'b0;
      #3 sclk = 1'b0;
    end
    #6 cs_n = 1'b1;
    drv = 1'b0;
    #40;
  endtask
endmodule

// ### verification/tb_top.sv
/*
  Self-checking bench for the volume control register bank.
  Assumes the host model and the bound checker; timeout of 50 clocks.
*/
`timescale 1ns/1ns
module tb_top;
  logic       clock;
  logic       rstn;
  logic       mute_n;
  logic       zcl;
  logic       zcr;
  logic       pkl;
  logic       pkr;
  wire        sclk;
  wire        cs_n;
  wire        din;
  logic       dout;
  logic       doe;
  logic       mute_out;
  logic       mute_oe;
  logic [7:0] lg;
  logic [7:0] rg;
  logic [7:0] ref_out;
  int         errors;
  int         checks_done;
  stereo_volume_control_regs #(.TIMEOUT_CYCLES(22'h000032)) i_dut (
    .clock(clock), .rstn(rstn), .control_serial_clock(sclk),
    .port_select_n(cs_n), .data_in(din), .data_out(dout),
    .data_oe(doe), .mute_input_n(mute_n), .mute_out(mute_out),
    .mute_oe(mute_oe), .zero_cross_left(zcl), .zero_cross_right(zcr),
    .peak_over_left(pkl), .peak_over_right(pkr), .left_gain_out(lg),
    .right_gain_out(rg), .peak_reference_out(ref_out)
  );
  host_serial_model i_host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .doe(doe)
  );
  // ==========================================================
  // Helpers
  task automatic chk(input string s, input logic [7:0] g,
                     input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [3:0] s, output logic [7:0] q);
    i_host.xfer({1'b1, s, 3'b111}, 8'h00, 16, q);
    cyc(1);
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d,
                    input logic hi = 1'b0);
    logic [7:0] q;
    i_host.xfer({hi, s, 1'b0, hi, hi}, d, 16, q);
    cyc(1);
  endtask
  task automatic blip(input logic [3:0] m);
    {zcl, zcr, pkl, pkr} = m;
    cyc(4);
    {zcl, zcr, pkl, pkr} = 4'h0;
    cyc(2);
  endtask
  task automatic expect_out(input logic l, input logic [7:0] e,
                            input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if ((l ? lg : rg) === e)
        break;
      cyc(1);
    end
    chk("gain_out", l ? lg : rg, e);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    logic [7:0] q;
    logic [7:0] e [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      rd(4'ha + 4'(i), q);
      chk("reg", q, e[i]);
    end
    chk("gain_out", lg | rg, 8'h00);
    chk("ref_out", ref_out, 8'hff);
  endtask
  task automatic t_gated;
    logic [7:0] q;
    wr(volume_ctrl_pkg::SEL_LEFT, 8'h80);
    chk("gain_out", lg, 8'h00);
    blip(4'h8);
    expect_out(1'b1, 8'h80, 8);
    rd(volume_ctrl_pkg::SEL_BUSY, q);
    chk("busy", q, 8'h00);
  endtask
  task automatic t_timeout_replace;
    logic [7:0] q;
    wr(volume_ctrl_pkg::SEL_RIGHT, 8'h40);
    wr(volume_ctrl_pkg::SEL_RIGHT, 8'h41);
    rd(volume_ctrl_pkg::SEL_BUSY, q);
    chk("busy", q, 8'h01);
    chk("gain_out", rg, 8'h00);
    expect_out(1'b0, 8'h41, 30);
    rd(volume_ctrl_pkg::SEL_BUSY, q);
    chk("busy", q, 8'h00);
  endtask
  task automatic t_mute_pin;
    mute_n = 1'b0;
    cyc(5);
    chk("gain_out", lg, 8'h80);
    blip(4'h8);
    expect_out(1'b1, 8'h00, 8);
    chk("gain_out", rg, 8'h41);
    expect_out(1'b0, 8'h00, 60);
    cyc(15);
    mute_n = 1'b1;
    expect_out(1'b1, 8'h80, 60);
    expect_out(1'b0, 8'h41, 60);
  endtask
  task automatic t_both_gated;
    logic [7:0] q;
    wr(volume_ctrl_pkg::CMD_BOTH, 8'h55);
    blip(4'h4);
    expect_out(1'b0, 8'h55, 8);
    chk("gain_out", lg, 8'h80);
    rd(volume_ctrl_pkg::SEL_BUSY, q);
    chk("busy", q, 8'h02);
    expect_out(1'b1, 8'h55, 60);
  endtask
  task automatic t_instant;
    logic [7:0] q;
    wr(volume_ctrl_pkg::CMD_INST_BOTH, 8'h56);
    expect_out(1'b1, 8'h56, 4);
    expect_out(1'b0, 8'h56, 1);
    wr(volume_ctrl_pkg::CMD_INST_ONE, 8'h57, 1'b1);
    expect_out(1'b1, 8'h57, 4);
    wr(volume_ctrl_pkg::CMD_INST_ONE, 8'h55, 1'b0);
    expect_out(1'b0, 8'h55, 4);
    rd(volume_ctrl_pkg::SEL_LEFT, q);
    chk("left_gain", q, 8'h57);
    rd(volume_ctrl_pkg::SEL_RIGHT, q);
    chk("right_gain", q, 8'h55);
  endtask
  task automatic t_peak;
    logic [7:0] q;
    wr(volume_ctrl_pkg::SEL_THRESH, 8'h30, 1'b1);
    chk("ref_out", ref_out, 8'h30);
    blip(4'h1);
    rd(volume_ctrl_pkg::SEL_PEAK, q);
    chk("peak", q, 8'h01);
    rd(volume_ctrl_pkg::SEL_PEAK, q);
    chk("peak", q, 8'h00);
    blip(4'h2);
    rd(volume_ctrl_pkg::SEL_PEAK, q);
    chk("peak", q, 8'h02);
  endtask
  task automatic t_refused;
    logic [7:0] q;
    wr(volume_ctrl_pkg::SEL_BUSY, 8'hff);
    wr(volume_ctrl_pkg::SEL_PEAK, 8'hff);
    rd(volume_ctrl_pkg::SEL_PEAK, q);
    chk("peak", q, 8'h00);
    i_host.xfer({1'b0, volume_ctrl_pkg::SEL_LEFT, 3'b000}, 8'h11, 15, q);
    cyc(1);
    i_host.xfer({1'b0, volume_ctrl_pkg::SEL_LEFT, 3'b000}, 8'h22, 17, q);
    cyc(1);
    rd(volume_ctrl_pkg::SEL_LEFT, q);
    chk("left_gain", q, 8'h57);
    rd(4'h0, q);
    chk("unmapped", q, 8'h00);
  endtask
  task automatic t_test_mode;
    logic [7:0] q;
    wr(volume_ctrl_pkg::SEL_TEST, 8'h02);
    chk("mute_oe", {7'h00, mute_oe}, 8'h01);
    zcl = 1'b1;
    cyc(3);
    chk("mute_out", {7'h00, mute_out}, 8'h01);
    zcl = 1'b0;
    expect_out(1'b1, 8'h00, 60);
    expect_out(1'b0, 8'h00, 60);
    wr(volume_ctrl_pkg::SEL_LEFT, 8'h99);
    rd(volume_ctrl_pkg::SEL_LEFT, q);
    chk("left_gain", q, 8'h57);
    wr(volume_ctrl_pkg::CMD_INST_BOTH, 8'h44);
    rd(volume_ctrl_pkg::SEL_RIGHT, q);
    chk("right_gain", q, 8'h44);
    chk("gain_out", lg, 8'h00);
    wr(volume_ctrl_pkg::SEL_TEST, 8'h00);
    chk("mute_oe", {7'h00, mute_oe}, 8'h00);
    expect_out(1'b1, 8'h44, 60);
  endtask
  // ==========================================================
  // Run control
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    #100000;
    errors++;
    summarize();
  end
  initial
  begin
    rstn = 1'b0;
    mute_n = 1'b1;
    {zcl, zcr, pkl, pkr} = 4'h0;
    repeat (3) @(posedge clock);
    #1 rstn = 1'b1;
    cyc(2);
    t_reset_values();
    t_gated();
    t_timeout_replace();
    t_mute_pin();
    t_both_gated();
    t_instant();
    t_peak();
    t_refused();
    t_test_mode();
    summarize();
  end
endmodule

// ### verification/volume_ctrl_chk.sv
/*
  Port checks for the volume control register bank.
  Assumes binding to the design top and the same timeout parameter.
*/
`timescale 1ns/1ns
module volume_ctrl_chk #(
  parameter logic [21:0] TIMEOUT_CYCLES = volume_ctrl_pkg::TIMEOUT_CYC
) (
  input wire logic       clock,             // System clock
  input wire logic       rstn,              // Async reset, low
  input wire logic       port_select_n,     // Frame select
  input wire logic       data_oe,           // Data pin enable
  input wire logic       mute_input_n,      // Mute pin level
  input wire logic       mute_oe,           // Mute pin enable
  input wire logic [7:0] left_gain_out,     // Left code
  input wire logic [7:0] right_gain_out,    // Right code
  input wire logic [7:0] peak_reference_out // Threshold code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Mute pin low time
  logic [31:0] mute_low_q;
  logic [31:0] mute_low_d;
  always_comb
  begin
    mute_low_d = mute_input_n ? 32'h00000000 : mute_low_q + 32'h00000001;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      mute_low_q <= 32'h00000000;
    else
      mute_low_q <= mute_low_d;
  end
  // ==========================================================
  // Properties
  property p_reset_state;
    $rose(rstn) |-> left_gain_out == 8'h00 && right_gain_out == 8'h00
      && peak_reference_out == 8'hff && !data_oe && !mute_oe;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");
  property p_idle_release;
    port_select_n && $past(port_select_n) |-> !data_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("data pin driven while deselected");
  property p_drive_in_frame;
    $rose(data_oe) |-> !port_select_n;
  endproperty
  a_drive_in_frame: assert property (p_drive_in_frame)
    else $error("data pin drive outside frame");
  property p_test_mutes_left;
    mute_oe && $changed(left_gain_out) |-> left_gain_out == 8'h00;
  endproperty
  a_test_mutes_left: assert property (p_test_mutes_left)
    else $error("left gain set in test mode");
  property p_test_mutes_right;
    mute_oe && $changed(right_gain_out) |-> right_gain_out == 8'h00;
  endproperty
  a_test_mutes_right: assert property (p_test_mutes_right)
    else $error("right gain set in test mode");
  property p_pin_mute;
    mute_low_q == 32'(TIMEOUT_CYCLES) + 32'h0000000a
      |-> left_gain_out == 8'h00 && right_gain_out == 8'h00;
  endproperty
  a_pin_mute: assert property (p_pin_mute)
    else $error("mute pin did not mute");
  property p_hold_mute;
    !mute_input_n [*6] ##1 $changed(left_gain_out) |-> left_gain_out == 8'h00;
  endproperty
  a_hold_mute: assert property (p_hold_mute)
    else $error("unmuted while mute pin low");
  property p_ref_commit;
    $changed(peak_reference_out)
      |-> $past(port_select_n) && !$past(port_select_n, 8);
  endproperty
  a_ref_commit: assert property (p_ref_commit)
    else $error("threshold changed outside frame commit");
endmodule
bind stereo_volume_control_regs volume_ctrl_chk #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_chk (
  .clock(clock),
  .rstn(rstn),
  .port_select_n(port_select_n),
  .data_oe(data_oe),
  .mute_input_n(mute_input_n),
  .mute_oe(mute_oe),
  .left_gain_out(left_gain_out),
  .right_gain_out(right_gain_out),
  .peak_reference_out(peak_reference_out)
);
